// file: shared/pcc_pkg.sv
// shared constants, types and helpers of the proximity calibration control
package pcc_pkg;
  // clock and converter timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int STAGE_T256_NS = 3072000;
  localparam int STAGE_T128_NS = 1525000;
  localparam int WAKE_STEP_MS = 200;
  localparam int STAGE256_CYC =
    (STAGE_T256_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAGE128_CYC =
    (STAGE_T128_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_STEP_CYC = WAKE_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FP_HOLD_MULT = 16;
  localparam int LP_HOLD_MULT = 4;
  localparam int NSTAGE = 8;
  // register indexes, byte address is four times the index
  localparam logic [9:0] REG_PWR = 10'h000;
  localparam logic [9:0] REG_HOLD = 10'h002;
  localparam logic [9:0] REG_THR = 10'h003;
  localparam logic [9:0] REG_TMO = 10'h004;
  localparam logic [9:0] REG_CTRL = 10'h006;
  localparam logic [9:0] REG_STAT = 10'h007;
  localparam logic [9:0] REG_RAW = 10'h00b;
  localparam logic [9:0] REG_BANK3 = 10'h0e0;
  // field positions
  localparam int WAKE_LSB = 2;
  localparam int DEC_LSB = 8;
  localparam int FPH_LSB = 4;
  localparam int LPH_LSB = 8;
  localparam int APPR_LSB = 0;
  localparam int HOV_LSB = 8;
  localparam int FPT_LSB = 0;
  localparam int LPT_LSB = 10;
  localparam int STG_LSB = 1;
  // writable bits and values after reset
  localparam logic [15:0] PWR_MASK = 16'h030c;
  localparam logic [15:0] HOLD_MASK = 16'h0ff0;
  localparam logic [15:0] THR_MASK = 16'h3fff;
  localparam logic [15:0] TMO_MASK = 16'hffff;
  localparam logic [15:0] CTRL_MASK = 16'h000f;
  localparam logic [15:0] PWR_RST = 16'h0000;
  localparam logic [15:0] HOLD_RST = 16'h0000;
  localparam logic [15:0] THR_RST = 16'h0000;
  localparam logic [15:0] TMO_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h000e;
  localparam logic [1:0] DEC_128 = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one converter result as delivered per stage
  typedef struct packed {
    logic [2:0] stage;
    logic [15:0] raw;
    logic [15:0] fast_word_one;
    logic [15:0] fast_word_three;
    logic [15:0] avg;
  } pcc_result_t;

  typedef enum logic [1:0] {
    PCC_CONV = 2'b01,
    PCC_WAKE = 2'b10
  } pcc_seq_state_t;

  // absolute difference of two codes
  function automatic logic [15:0] pcc_absdiff(input logic [15:0] a,
                                              input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : pcc_absdiff
endpackage : pcc_pkg

// file: hdl/pcc_seq_timer.sv
// conversion sequence timer with low-power wake-up delay
`timescale 1ns/10ps
module pcc_seq_timer #(
  parameter int STAGE256_CYC = pcc_pkg::STAGE256_CYC,
  parameter int STAGE128_CYC = pcc_pkg::STAGE128_CYC,
  parameter int WAKE_STEP_CYC = pcc_pkg::WAKE_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic low_power,
  input wire logic dec128,
  input wire logic [2:0] stage_num,
  input wire logic [1:0] wake_sel,
  output logic stage_go_q,
  output logic [2:0] stage_q,
  output logic seq_end_q
);
  if (STAGE256_CYC < 1 || STAGE128_CYC < 1 || WAKE_STEP_CYC < 1 ||
      WAKE_STEP_CYC > 4194303 || STAGE256_CYC > 16777215 ||
      STAGE128_CYC > 16777215) begin : g_chk
    $error("pcc_seq_timer: cycle counts out of range");
  end

  pcc_pkg::pcc_seq_state_t state_q;
  logic [23:0] cnt_q;
  logic [23:0] stage_len;
  logic [23:0] wake_len;

  // per-stage time and wake delay in cycles
  always_comb begin
    stage_len = dec128 ? 24'(STAGE128_CYC - 1) : 24'(STAGE256_CYC - 1);
    wake_len = 24'(WAKE_STEP_CYC) * ({22'h0, wake_sel} + 24'h1) - 24'h1;
  end

  // stage stepping, sequence end and wake wait
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= pcc_pkg::PCC_WAKE;
      cnt_q <= 24'h0;
      stage_q <= 3'h0;
      stage_go_q <= 1'b0;
      seq_end_q <= 1'b0;
    end else begin
      stage_go_q <= 1'b0;
      seq_end_q <= 1'b0;
      case (state_q)
        pcc_pkg::PCC_CONV: begin
          if (cnt_q != 24'h0) begin
            cnt_q <= cnt_q - 24'h1;
          end else if (stage_q == stage_num) begin
            seq_end_q <= 1'b1;
            stage_q <= 3'h0;
            if (low_power) begin
              state_q <= pcc_pkg::PCC_WAKE;
              cnt_q <= wake_len;
            end else begin
              stage_go_q <= 1'b1;
              cnt_q <= stage_len;
            end
          end else begin
            stage_q <= stage_q + 3'h1;
            stage_go_q <= 1'b1;
            cnt_q <= stage_len;
          end
        end
        pcc_pkg::PCC_WAKE: begin
          if (cnt_q != 24'h0) begin
            cnt_q <= cnt_q - 24'h1;
          end else begin
            state_q <= pcc_pkg::PCC_CONV;
            stage_go_q <= 1'b1;
            cnt_q <= stage_len;
          end
        end
        default: begin
          state_q <= pcc_pkg::PCC_WAKE;
          cnt_q <= 24'h0;
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_wake_delay_len: assert property (
    seq_end_q && $past(low_power) |-> state_q == pcc_pkg::PCC_WAKE &&
      cnt_q == 24'(WAKE_STEP_CYC) * ({22'h0, $past(wake_sel)} + 24'h1)
      - 24'h1)
    else $error("wake delay not loaded from wake select");
  a_fp_no_wait: assert property (
    seq_end_q && !$past(low_power) |-> stage_go_q && stage_q == 3'h0)
    else $error("full power sequence did not restart at once");
  c_wake_seen: cover property (seq_end_q && state_q == pcc_pkg::PCC_WAKE);
endmodule : pcc_seq_timer

// file: hdl/pcc_top.sv
// proximity calibration control with AXI4-Lite register slave
// Functional notes
// - low-power wait between sequences is 200/400/600/800 ms by wake select.
// - wake select 3 gives one sequence every 800 ms of delay.
// - low-power period is sequence time followed by the wake delay.
// - latest raw 16-bit converter word is readable at index 0x00b.
// - per-stage results are held in a readable bank for the host.
// - every stage is watched; a detection stops ambient calibration at once.
// - full-power hold lasts hold count times 16 sequences.
// - low-power hold lasts hold count times 4 sequences.
// - after the hold, calibration resumes only without proximity.
// - hover excess lasting the whole timeout forces a recalibration.
// - full-power timeout is its field times one sequence.
// - low-power timeout is its field times one sequence.
// - proximity is the approach comparator or the hover comparator.
// - approach when |word one - word three| exceeds the 0x003[7:0] level.
// - hover when |average - ambient| exceeds the 0x003[13:8] level.
// - hold counts sit at 0x002[7:4] full and 0x002[11:8] low power.
// - timeouts sit at 0x004[9:0] full and 0x004[15:10] low power.
// - 0x000[9:8] selects ratio 256 (00) or 128 (01).
// - sequence time is stages times 3.072 ms or 1.525 ms.
`timescale 1ns/10ps
module pcc_top #(
  parameter int STAGE256_CYC = pcc_pkg::STAGE256_CYC,
  parameter int STAGE128_CYC = pcc_pkg::STAGE128_CYC,
  parameter int WAKE_STEP_CYC = pcc_pkg::WAKE_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic res_valid,
  input wire pcc_pkg::pcc_result_t res,
  output logic conv_start,
  output logic [2:0] conv_stage,
  output logic seq_done,
  output logic prox_flag,
  output logic cal_hold,
  output logic recal_pulse
);
  localparam int NS = pcc_pkg::NSTAGE;

  // registers
  logic [15:0] pwr_q, hold_cfg_q, thr_q, tmo_q, ctrl_q, raw_q;
  logic [15:0] avg_q [NS];
  logic [15:0] amb_q [NS];
  logic [NS-1:0] seeded_q;
  // bus state
  logic aw_have_q, w_have_q;
  logic [9:0] widx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic write_go;
  // proximity state
  logic prox_q, prox_acc_q, exceed_acc_q, cal_dis_q, force_q;
  logic [7:0] hold_q;
  logic [9:0] recal_cnt_q;
  // decoded fields
  logic low_power, dec128;
  logic [1:0] wake_sel;
  logic [2:0] stage_num;
  logic [7:0] appr_thr, fp_hold_ld, lp_hold_ld, hold_ld;
  logic [5:0] hov_thr, lp_tmo;
  logic [9:0] fp_tmo, tmo_sel;
  logic appr, hov, det, exceed;
  logic seq_end;

  // field decode
  always_comb begin
    wake_sel = pwr_q[pcc_pkg::WAKE_LSB +: 2];
    dec128 = pwr_q[pcc_pkg::DEC_LSB +: 2] == pcc_pkg::DEC_128;
    low_power = ctrl_q[0];
    stage_num = ctrl_q[pcc_pkg::STG_LSB +: 3];
    fp_hold_ld = 8'(pcc_pkg::FP_HOLD_MULT) *
      {4'h0, hold_cfg_q[pcc_pkg::FPH_LSB +: 4]};
    lp_hold_ld = 8'(pcc_pkg::LP_HOLD_MULT) *
      {4'h0, hold_cfg_q[pcc_pkg::LPH_LSB +: 4]};
    hold_ld = low_power ? lp_hold_ld : fp_hold_ld;
    appr_thr = thr_q[pcc_pkg::APPR_LSB +: 8];
    hov_thr = thr_q[pcc_pkg::HOV_LSB +: 6];
    fp_tmo = tmo_q[pcc_pkg::FPT_LSB +: 10];
    lp_tmo = tmo_q[pcc_pkg::LPT_LSB +: 6];
    tmo_sel = low_power ? {4'h0, lp_tmo} : fp_tmo;
  end

  // comparators on the incoming stage result
  always_comb begin
    appr = pcc_pkg::pcc_absdiff(res.fast_word_one, res.fast_word_three)
      > {8'h0, appr_thr};
    hov = seeded_q[res.stage] &&
      pcc_pkg::pcc_absdiff(res.avg, amb_q[res.stage]) > {10'h0, hov_thr};
    det = res_valid && (appr || hov);
    exceed = res_valid && seeded_q[res.stage] &&
      {1'b0, res.avg} > {1'b0, amb_q[res.stage]} + {11'h0, hov_thr};
  end

  // sequence timing
  pcc_seq_timer #(
    .STAGE256_CYC(STAGE256_CYC),
    .STAGE128_CYC(STAGE128_CYC),
    .WAKE_STEP_CYC(WAKE_STEP_CYC)
  ) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .low_power(low_power),
    .dec128(dec128),
    .stage_num(stage_num),
    .wake_sel(wake_sel),
    .stage_go_q(conv_start),
    .stage_q(conv_stage),
    .seq_end_q(seq_end)
  );

  // write address and data taken in either order
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      widx_q <= 10'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        widx_q <= s_axi_awaddr[11:2];
        s_axi_awready <= 1'b0;
      end else if (write_go) begin
        aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (write_go) begin
        w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign write_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // merge a write into a 16-bit register by byte strobes
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] mask);
    logic [15:0] nv;
    nv = {wstrb_q[1] ? wdata_q[15:8] : old[15:8],
          wstrb_q[0] ? wdata_q[7:0] : old[7:0]};
    return nv & mask;
  endfunction : merge

  function automatic logic known(input logic [9:0] idx);
    return idx == pcc_pkg::REG_PWR || idx == pcc_pkg::REG_HOLD ||
      idx == pcc_pkg::REG_THR || idx == pcc_pkg::REG_TMO ||
      idx == pcc_pkg::REG_CTRL || idx == pcc_pkg::REG_STAT ||
      idx == pcc_pkg::REG_RAW || idx[9:3] == pcc_pkg::REG_BANK3[9:3];
  endfunction : known

  // control registers and write response
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwr_q <= pcc_pkg::PWR_RST;
      hold_cfg_q <= pcc_pkg::HOLD_RST;
      thr_q <= pcc_pkg::THR_RST;
      tmo_q <= pcc_pkg::TMO_RST;
      ctrl_q <= pcc_pkg::CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcc_pkg::RESP_OKAY;
    end else if (write_go) begin
      if (widx_q == pcc_pkg::REG_PWR) begin
        pwr_q <= merge(pwr_q, pcc_pkg::PWR_MASK);
      end else if (widx_q == pcc_pkg::REG_HOLD) begin
        hold_cfg_q <= merge(hold_cfg_q, pcc_pkg::HOLD_MASK);
      end else if (widx_q == pcc_pkg::REG_THR) begin
        thr_q <= merge(thr_q, pcc_pkg::THR_MASK);
      end else if (widx_q == pcc_pkg::REG_TMO) begin
        tmo_q <= merge(tmo_q, pcc_pkg::TMO_MASK);
      end else if (widx_q == pcc_pkg::REG_CTRL) begin
        ctrl_q <= merge(ctrl_q, pcc_pkg::CTRL_MASK);
      end
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known(widx_q) ? pcc_pkg::RESP_OKAY
                                   : pcc_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, data one edge after the address is taken
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= pcc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known(s_axi_araddr[11:2]) ? pcc_pkg::RESP_OKAY
                                               : pcc_pkg::RESP_SLVERR;
      if (s_axi_araddr[11:2] == pcc_pkg::REG_PWR) begin
        s_axi_rdata <= {16'h0, pwr_q};
      end else if (s_axi_araddr[11:2] == pcc_pkg::REG_HOLD) begin
        s_axi_rdata <= {16'h0, hold_cfg_q};
      end else if (s_axi_araddr[11:2] == pcc_pkg::REG_THR) begin
        s_axi_rdata <= {16'h0, thr_q};
      end else if (s_axi_araddr[11:2] == pcc_pkg::REG_TMO) begin
        s_axi_rdata <= {16'h0, tmo_q};
      end else if (s_axi_araddr[11:2] == pcc_pkg::REG_CTRL) begin
        s_axi_rdata <= {16'h0, ctrl_q};
      end else if (s_axi_araddr[11:2] == pcc_pkg::REG_STAT) begin
        s_axi_rdata <= {16'h0, recal_cnt_q, 4'h0, cal_dis_q, prox_q};
      end else if (s_axi_araddr[11:2] == pcc_pkg::REG_RAW) begin
        s_axi_rdata <= {16'h0, raw_q};
      end else if (s_axi_araddr[11:5] == pcc_pkg::REG_BANK3[9:3]) begin
        s_axi_rdata <= {16'h0, avg_q[s_axi_araddr[4:2]]};
      end else begin
        s_axi_rdata <= 32'h0;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // raw word and per-stage result bank
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      raw_q <= 16'h0;
      for (int i = 0; i < NS; i++) begin
        avg_q[i] <= 16'h0;
      end
    end else if (res_valid) begin
      raw_q <= res.raw;
      avg_q[res.stage] <= res.avg;
    end
  end

  // ambient values: seeded, tracked while calibrating, reloaded on force
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seeded_q <= '0;
      for (int i = 0; i < NS; i++) begin
        amb_q[i] <= 16'h0;
      end
    end else if (force_q) begin
      for (int i = 0; i < NS; i++) begin
        amb_q[i] <= avg_q[i];
      end
    end else if (res_valid && (!seeded_q[res.stage] ||
                 (!cal_dis_q && !det))) begin
      amb_q[res.stage] <= res.avg;
      seeded_q[res.stage] <= 1'b1;
    end
  end

  // proximity flags per sequence
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prox_q <= 1'b0;
      prox_acc_q <= 1'b0;
      exceed_acc_q <= 1'b0;
    end else if (force_q) begin
      prox_q <= 1'b0;
      prox_acc_q <= 1'b0;
      exceed_acc_q <= 1'b0;
    end else if (seq_end) begin
      prox_q <= prox_acc_q || det;
      prox_acc_q <= det;
      exceed_acc_q <= exceed;
    end else begin
      prox_acc_q <= prox_acc_q || det;
      exceed_acc_q <= exceed_acc_q || exceed;
    end
  end

  // calibration hold period after a detection
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal_dis_q <= 1'b0;
      hold_q <= 8'h0;
    end else if (force_q) begin
      cal_dis_q <= 1'b0;
      hold_q <= 8'h0;
    end else if (det && !cal_dis_q) begin
      cal_dis_q <= 1'b1;
      hold_q <= hold_ld;
    end else if (seq_end && cal_dis_q) begin
      if (hold_q > 8'h1) begin
        hold_q <= hold_q - 8'h1;
      end else if (!prox_acc_q && !det) begin
        cal_dis_q <= 1'b0;
        hold_q <= 8'h0;
      end else begin
        hold_q <= hold_ld;
      end
    end
  end

  // recalibration timeout counted in sequences
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      recal_cnt_q <= 10'h0;
      force_q <= 1'b0;
    end else begin
      force_q <= 1'b0;
      if (force_q) begin
        recal_cnt_q <= 10'h0;
      end else if (seq_end) begin
        if (!(exceed_acc_q || exceed)) begin
          recal_cnt_q <= 10'h0;
        end else if (tmo_sel != 10'h0 &&
                     recal_cnt_q + 10'h1 >= tmo_sel) begin
          force_q <= 1'b1;
          recal_cnt_q <= 10'h0;
        end else begin
          recal_cnt_q <= recal_cnt_q + 10'h1;
        end
      end
    end
  end

  assign seq_done = seq_end;
  assign prox_flag = prox_q;
  assign cal_hold = cal_dis_q;
  assign recal_pulse = force_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_raw_readback: assert property (
    res_valid |=> raw_q == $past(res.raw))
    else $error("raw word not captured");
  a_bank_holds: assert property (
    res_valid |=> avg_q[$past(res.stage)] == $past(res.avg))
    else $error("stage result not held");
  a_detect_stops_cal: assert property (
    det && !force_q |=> cal_dis_q)
    else $error("calibration not stopped on detection");
  a_approach_flag: assert property (
    res_valid && !force_q && pcc_pkg::pcc_absdiff(res.fast_word_one,
      res.fast_word_three) > {8'h0, thr_q[7:0]} |=> prox_acc_q)
    else $error("approach comparator missed");
  a_hover_flag: assert property (
    res_valid && !force_q && seeded_q[res.stage] &&
    pcc_pkg::pcc_absdiff(res.avg, amb_q[res.stage]) > {10'h0, thr_q[13:8]}
    |=> prox_acc_q)
    else $error("hover comparator missed");
  a_fp_hold_load: assert property (
    !cal_dis_q && det && !force_q && !ctrl_q[0]
    |=> hold_q == 8'(16 * $past(hold_cfg_q[7:4])))
    else $error("full power hold not sixteen sequences per count");
  a_lp_hold_load: assert property (
    !cal_dis_q && det && !force_q && ctrl_q[0]
    |=> hold_q == 8'(4 * $past(hold_cfg_q[11:8])))
    else $error("low power hold not four sequences per count");
  a_resume_clean: assert property (
    $fell(cal_dis_q) && !$past(force_q)
    |-> $past(seq_end) && !$past(prox_acc_q) && $past(hold_q) <= 8'h1)
    else $error("calibration resumed early or with proximity");
  a_force_clears: assert property (
    force_q |=> !prox_q && !cal_dis_q && recal_cnt_q == 10'h0)
    else $error("forced recalibration did not clear state");
  a_force_cause: assert property (
    force_q |-> $past(seq_end) && $past(tmo_sel) != 10'h0)
    else $error("forced recalibration without timeout");
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  c_forced_recal: cover property (force_q);
  c_cal_resumed: cover property ($fell(cal_dis_q) && !$past(force_q));
  c_lp_sequence: cover property (seq_end && ctrl_q[0] && det);
endmodule : pcc_top

// file: tb/pcc_conv_model.sv
// behavioural converter answering each stage start with one result
`timescale 1ns/10ps
module pcc_conv_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic [2:0] conv_stage,
  input wire logic [3:0] lag,
  input wire logic [15:0] level,
  input wire logic [15:0] swing,
  output logic res_valid,
  output pcc_pkg::pcc_result_t res
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [2:0] stg_q;
  // result lag plus one cycles after the start is taken; the bus toggles between results
  always_ff @(posedge mclk) begin
    res_valid <= 1'h0;
    res <= ~res;
    if (!rst_n) begin
      busy_q <= 1'h0;
      res <= '0;
    end else if (conv_start) begin
      busy_q <= 1'h1;
      cnt_q <= lag;
      stg_q <= conv_stage;
    end else if (busy_q && cnt_q == 4'h0) begin
      busy_q <= 1'h0;
      res_valid <= 1'h1;
      res <= {stg_q, level, level + swing, level, level};
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : pcc_conv_model

// file: tb/proximity_calibration_control_test.sv
// self-checking bench of the proximity calibration control
`timescale 1ns/10ps
module proximity_calibration_control_test;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, res_valid, conv_start, seq_done, prox_flag;
  logic cal_hold, recal_pulse;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] conv_stage;
  pcc_pkg::pcc_result_t res;
  logic [15:0] level = 16'h1234, swing = 16'h0000;
  logic [3:0] lag = 4'h1;
  int fail_count = 0, cmp_count = 0, n, c;

  // short counts keep the run brief
  pcc_top #(.STAGE256_CYC(8), .STAGE128_CYC(4), .WAKE_STEP_CYC(20))
    pcc_top_inst (.*);
  pcc_conv_model pcc_conv_model_inst (.*);

  always #50 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // one clock with a bound on every wait
  task automatic step();
    @(posedge mclk);
    n++;
    if (n > 3000) begin
      fail_count++;
      $display("Error timeout expected 0 seen 1");
      results();
    end
  endtask : step

  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] er = pcc_pkg::RESP_OKAY);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      step();
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'h0;
    chk("bresp", er, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] e,
                    input logic [1:0] er = pcc_pkg::RESP_OKAY);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      step();
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'h0;
    chk("rdata", {16'h0000, e}, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask : rd

  task automatic wait_seq();
    n = 0;
    do step(); while (!seq_done);
  endtask : wait_seq

  // cycles between two sequence ends, skipping the one in progress and the one after it
  task automatic period(input int e);
    wait_seq();
    wait_seq();
    c = 0;
    do begin
      step();
      c++;
    end while (!seq_done);
    chk("period", e, c);
  endtask : period

  // main sequence of register and timing scenarios
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    rd(12'h000, 16'h0000);
    rd(12'h008, 16'h0000);
    rd(12'h010, 16'h0000);
    rd(12'h018, 16'h000e);
    rd(12'h004, 16'h0000, pcc_pkg::RESP_SLVERR);
    wr(12'h004, 16'hffff, pcc_pkg::RESP_SLVERR);
    wr(12'h000, 16'hffff);
    rd(12'h000, 16'h030c);
    wr(12'h008, 16'hffff);
    rd(12'h008, 16'h0ff0);
    wr(12'h00c, 16'hffff);
    rd(12'h00c, 16'h3fff);
    wr(12'h010, 16'hffff);
    rd(12'h010, 16'hffff);
    wr(12'h010, 16'h0000);
    wr(12'h000, 16'h0000);
    wr(12'h018, 16'h0000);
    period(8);
    wr(12'h018, 16'h0002);
    period(16);
    wr(12'h018, 16'h0000);
    wr(12'h000, 16'h0100);
    lag <= 4'h2;
    period(4);
    wr(12'h018, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wr(12'h000, 16'(k << 2));
      period(8 + (k + 1) * 20);
    end
    wr(12'h018, 16'h0000);
    rd(12'h02c, 16'h1234);
    rd(12'h380, 16'h1234);
    wr(12'h008, 16'h0010);
    wr(12'h00c, 16'h0004);
    swing <= 16'h0004;
    repeat (3) wait_seq();
    chk("cal_hold", 1'h0, cal_hold);
    swing <= 16'h0005;
    n = 0;
    do step(); while (!cal_hold);
    swing <= 16'h0000;
    wait_seq();
    step();
    chk("prox_flag", 1'h1, prox_flag);
    c = 1;
    n = 0;
    do begin
      step();
      if (seq_done && cal_hold) c++;
    end while (cal_hold);
    chk("hold_seqs", 16, c);
    wr(12'h00c, 16'h0aff);
    wr(12'h010, 16'h0003);
    level <= 16'h123f;
    c = 0;
    n = 0;
    do begin
      step();
      if (seq_done) c++;
    end while (!recal_pulse);
    chk("recal_seqs", 1'h1, c > 2 && c < 5);
    repeat (2) wait_seq();
    chk("prox_after", 1'h0, prox_flag);
    chk("hold_after", 1'h0, cal_hold);
    // low-power hold of one count lasts four sequences
    wr(12'h018, 16'h0001);
    wr(12'h008, 16'h0100);
    swing <= 16'h0100;
    n = 0;
    do step(); while (!cal_hold);
    swing <= 16'h0000;
    c = 0;
    n = 0;
    do begin
      step();
      if (seq_done && cal_hold) c++;
    end while (cal_hold);
    chk("lp_hold_seqs", 4, c);
    rd(12'h01c, 16'h0000);
    results();
  end
endmodule : proximity_calibration_control_test
